// file: hw/idc_pkg.sv
// ==============================================
// shared constants and carriers
// ==============================================
package idc_pkg;

	// ==============================================
	// register offsets, index 0 is the first input
	// ==============================================
	localparam logic [3:0][7:0] DIV_HIGH_OFS = {8'h34, 8'h31, 8'h2E, 8'h2B};
	localparam logic [3:0][7:0] DIV_MID_OFS  = {8'h35, 8'h32, 8'h2F, 8'h2C};
	localparam logic [3:0][7:0] DIV_LOW_OFS  = {8'h36, 8'h33, 8'h30, 8'h2D};
	localparam logic [7:0]      BAND_OFS     = 8'h37;

	// ==============================================
	// field layout
	// ==============================================
	localparam int DIV_W        = 19;
	localparam int DIV_HIGH_W   = 3;
	localparam int DIV_HIGH_LSB = 16;
	localparam int DIV_MID_LSB  = 8;
	localparam int BAND_W       = 3;
	localparam int BAND_IN1_LSB = 0;
	localparam int BAND_IN2_LSB = 3;
	localparam int MHZ_W        = 10;

	// first reserved band code; 6 and 7 are both reserved
	localparam logic [2:0] BAND_RSV_FIRST = 3'h6;

	// ==============================================
	// reset values
	// ==============================================
	localparam logic [7:0] RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] RST_DIV_MID  = 8'h00;
	localparam logic [7:0] RST_IN1_LOW  = 8'h00;
	localparam logic [7:0] RST_IN2_LOW  = 8'h09;
	localparam logic [7:0] RST_IN3_LOW  = 8'h00;
	localparam logic [7:0] RST_IN4_LOW  = 8'h09;
	localparam logic [3:0][7:0] DIV_LOW_RST = {RST_IN4_LOW, RST_IN3_LOW, RST_IN2_LOW, RST_IN1_LOW};
	localparam logic [7:0] RST_BAND     = 8'h00;

	// ==============================================
	// expected input band limits in MHz, codes 0 to 5
	// ==============================================
	localparam logic [5:0][9:0] BAND_LO_MHZ = {10'h177, 10'h0BE, 10'h05F, 10'h032, 10'h019, 10'h00A};
	localparam logic [5:0][9:0] BAND_HI_MHZ = {10'h2C6, 10'h1B3, 10'h0D7, 10'h069, 10'h036, 10'h01B};

	// ==============================================
	// carriers
	// ==============================================
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} idc_req_t;

	typedef struct packed {
		logic [18:0] value;
		logic [19:0] ratio;
		logic        changed;
	} idc_div_t;

	typedef struct packed {
		logic [2:0] code;
		logic       reserved;
		logic [9:0] lo_mhz;
		logic [9:0] hi_mhz;
	} idc_band_t;

endpackage : idc_pkg

// file: hw/idc_div_bank.sv
`timescale 1ns/10ps
// ==============================================
// one 19-bit input divider over three byte registers
// ==============================================
module idc_div_bank #(
	parameter logic [7:0] LOW_RST = 8'h00
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  wr_sel,
	input  wire logic [7:0]  wdata,
	output logic      [18:0] value,
	output logic             changed
);

	logic [18:0] value_q;
	logic [18:0] value_d;
	logic        changed_q;
	logic        changed_d;

	// byte merge: bit 2 high, bit 1 middle, bit 0 low
	always_comb begin
		value_d = value_q;
		if (wr_sel[2]) begin
			value_d[18:16] = wdata[2:0];   // upper five bits dropped, they read zero
		end
		if (wr_sel[1]) begin
			value_d[15:8] = wdata;
		end
		if (wr_sel[0]) begin
			value_d[7:0] = wdata;
		end
		changed_d = (value_d != value_q);
	end

	// reset loads high, middle and low bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q   <= {idc_pkg::RST_DIV_HIGH[2:0], idc_pkg::RST_DIV_MID, LOW_RST};
			changed_q <= 1'b0;
		end else begin
			value_q   <= value_d;
			changed_q <= changed_d;
		end
	end

	assign value   = value_q;
	assign changed = changed_q;

endmodule : idc_div_bank

// file: hw/idc_band_reg.sv
`timescale 1ns/10ps
// ==============================================
// band-select byte for the first two inputs
// ==============================================
module idc_band_reg (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [2:0] code1,
	output logic      [2:0] code2
);

	logic [5:0] band_q;
	logic [5:0] band_d;

	// codes kept as written, reserved ones too, so readback is honest
	always_comb begin
		band_d = band_q;
		if (wr) begin
			band_d = wdata[5:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			band_q <= idc_pkg::RST_BAND[5:0];
		end else begin
			band_q <= band_d;
		end
	end

	assign code1 = band_q[idc_pkg::BAND_IN1_LSB +: idc_pkg::BAND_W];
	assign code2 = band_q[idc_pkg::BAND_IN2_LSB +: idc_pkg::BAND_W];

endmodule : idc_band_reg

// file: hw/idc_top.sv
// What this block does
// - input 1 holds 19-bit divider, zero divides one
// - input 2 holds 19-bit divider, same layout
// - input 3 holds 19-bit divider, same layout
// - input 4 holds 19-bit divider, same layout
// - two 3-bit band codes, six bands, 6-7 reserved
// - low bytes of inputs 2 and 4 reset 09
`timescale 1ns/10ps
module idc_top (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire idc_pkg::idc_req_t         req,
	output logic      [7:0]                rd_data,
	output logic                           rd_valid,
	output logic                           unmapped,
	output idc_pkg::idc_div_t  [3:0]       div_cfg,
	output idc_pkg::idc_band_t [1:0]       band_cfg
);

	// ==============================================
	// declarations
	// ==============================================
	logic [3:0][2:0]             wr_sel;
	logic                        band_wr;
	logic [3:0][18:0]            div_value;
	logic [3:0]                  div_changed;
	logic [2:0]                  band_code1;
	logic [2:0]                  band_code2;
	logic [7:0]                  rd_data_q;
	logic [7:0]                  rd_data_d;
	logic                        rd_valid_q;
	logic                        rd_valid_d;
	logic                        unmapped_q;
	logic                        unmapped_d;
	idc_pkg::idc_div_t  [3:0]    div_cfg_q;
	idc_pkg::idc_div_t  [3:0]    div_cfg_d;
	idc_pkg::idc_band_t [1:0]    band_cfg_q;
	idc_pkg::idc_band_t [1:0]    band_cfg_d;

	// ==============================================
	// address decode
	// ==============================================
	// one-hot hit per divider byte; bit 2 high, 1 middle, 0 low
	function automatic logic [3:0][2:0] div_hit(input logic [7:0] addr);
		logic [3:0][2:0] hit;
		hit = '0;
		for (int i = 0; i < 4; i++) begin
			hit[i][2] = (addr == idc_pkg::DIV_HIGH_OFS[i]);
			hit[i][1] = (addr == idc_pkg::DIV_MID_OFS[i]);
			hit[i][0] = (addr == idc_pkg::DIV_LOW_OFS[i]);
		end
		return hit;
	endfunction : div_hit

	// any mapped register at this offset
	function automatic logic is_mapped(input logic [7:0] addr);
		return (|div_hit(addr)) || (addr == idc_pkg::BAND_OFS);
	endfunction : is_mapped

	// ==============================================
	// write strobes
	// ==============================================
	// the serial port core hands a whole byte per write
	always_comb begin
		wr_sel = '0;
		if (req.wr) begin
			wr_sel = div_hit(req.addr);
		end
		band_wr = req.wr && (req.addr == idc_pkg::BAND_OFS);
	end

	// ==============================================
	// divider byte registers
	// ==============================================
	// each input gets its own bank; only the low-byte reset differs
	for (genvar g = 0; g < 4; g++) begin : g_div
		idc_div_bank #(
			.LOW_RST (idc_pkg::DIV_LOW_RST[g])
		) u_bank (
			.clk     (clk),
			.rst_n   (rst_n),
			.wr_sel  (wr_sel[g]),
			.wdata   (req.wdata),
			.value   (div_value[g]),
			.changed (div_changed[g])
		);
	end

	// ==============================================
	// band-select register
	// ==============================================
	idc_band_reg u_band (
		.clk   (clk),
		.rst_n (rst_n),
		.wr    (band_wr),
		.wdata (req.wdata),
		.code1 (band_code1),
		.code2 (band_code2)
	);

	// ==============================================
	// readback
	// ==============================================
	// reserved upper bits always read zero
	function automatic logic [7:0] read_byte(
		input logic [7:0]       addr,
		input logic [3:0][18:0] dv,
		input logic [2:0]       c1,
		input logic [2:0]       c2
	);
		logic [3:0][2:0] hit;
		logic [7:0]      res;
		hit = div_hit(addr);
		res = 8'h00;
		for (int i = 0; i < 4; i++) begin
			if (hit[i][2]) begin
				res = {5'h00, dv[i][18:16]};
			end
			if (hit[i][1]) begin
				res = dv[i][15:8];
			end
			if (hit[i][0]) begin
				res = dv[i][7:0];
			end
		end
		if (addr == idc_pkg::BAND_OFS) begin
			res = {2'h0, c2, c1};
		end
		return res;
	endfunction : read_byte

	// read answers one cycle after the request, old value if written together
	always_comb begin
		rd_valid_d = req.rd;
		rd_data_d  = rd_data_q;
		if (req.rd) begin
			rd_data_d = read_byte(req.addr, div_value, band_code1, band_code2);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	// ==============================================
	// unmapped access flag
	// ==============================================
	// writes elsewhere are dropped; this pulse lets the port core report it
	always_comb begin
		unmapped_d = (req.wr || req.rd) && !is_mapped(req.addr);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unmapped_q <= 1'b0;
		end else begin
			unmapped_q <= unmapped_d;
		end
	end

	// ==============================================
	// divider outputs to the input datapaths
	// ==============================================
	// stored value zero means divide by one, so ratio is value plus one
	function automatic logic [19:0] div_ratio(input logic [18:0] v);
		return {1'b0, v} + 20'h0_0001;
	endfunction : div_ratio

	always_comb begin
		div_cfg_d = div_cfg_q;
		for (int i = 0; i < 4; i++) begin
			div_cfg_d[i].value   = div_value[i];
			div_cfg_d[i].ratio   = div_ratio(div_value[i]);
			div_cfg_d[i].changed = div_changed[i];
		end
	end

	// value and change pulse leave together, one register stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				div_cfg_q[i].value   <= {idc_pkg::RST_DIV_HIGH[2:0], idc_pkg::RST_DIV_MID,
				                         idc_pkg::DIV_LOW_RST[i]};
				div_cfg_q[i].ratio   <= div_ratio({idc_pkg::RST_DIV_HIGH[2:0], idc_pkg::RST_DIV_MID,
				                                   idc_pkg::DIV_LOW_RST[i]});
				div_cfg_q[i].changed <= 1'b0;
			end
		end else begin
			div_cfg_q <= div_cfg_d;
		end
	end

	// ==============================================
	// band outputs to the offset alarm monitor
	// ==============================================
	// reserved codes give zero limits; the monitor should hold off then
	function automatic idc_pkg::idc_band_t band_info(input logic [2:0] code);
		idc_pkg::idc_band_t b;
		b.code     = code;
		b.reserved = (code >= idc_pkg::BAND_RSV_FIRST);
		b.lo_mhz   = '0;
		b.hi_mhz   = '0;
		if (!b.reserved) begin
			b.lo_mhz = idc_pkg::BAND_LO_MHZ[code];
			b.hi_mhz = idc_pkg::BAND_HI_MHZ[code];
		end
		return b;
	endfunction : band_info

	always_comb begin
		band_cfg_d[0] = band_info(band_code1);
		band_cfg_d[1] = band_info(band_code2);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			band_cfg_q[0] <= band_info(idc_pkg::RST_BAND[idc_pkg::BAND_IN1_LSB +: idc_pkg::BAND_W]);
			band_cfg_q[1] <= band_info(idc_pkg::RST_BAND[idc_pkg::BAND_IN2_LSB +: idc_pkg::BAND_W]);
		end else begin
			band_cfg_q <= band_cfg_d;
		end
	end

	// ==============================================
	// outputs
	// ==============================================
	assign rd_data  = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign unmapped = unmapped_q;
	assign div_cfg  = div_cfg_q;
	assign band_cfg = band_cfg_q;

endmodule : idc_top

// file: test/idc_top_properties.sv
`timescale 1ns/10ps
// ======================
// port properties
// ======================
module idc_top_properties (
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire idc_pkg::idc_req_t        req,
	input wire logic [7:0]               rd_data,
	input wire logic                     rd_valid,
	input wire logic                     unmapped,
	input wire idc_pkg::idc_div_t [3:0]  div_cfg,
	input wire idc_pkg::idc_band_t [1:0] band_cfg
);
	// one domain, so one default clock and reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// read answers: exactly one cycle after the request
	a_read_answered: assert property (req.rd |=> rd_valid) else $error("read not answered");
	a_read_no_spurious: assert property (rd_valid |-> $past(req.rd)) else $error("spurious read answer");
	a_unmapped_flag: assert property ((req.wr || req.rd) && (req.addr < 8'h2b || req.addr > 8'h37) |=> unmapped)
		else $error("unmapped access not flagged");
	// datapath sees a written byte from the second edge on
	a_in1_low_byte: assert property (
		req.wr && req.addr == 8'h2d |=> ##1 div_cfg[0].value[7:0] == $past(req.wdata, 2))
		else $error("input 1 low byte wrong");
	a_in2_high_bits: assert property (req.wr && req.addr == 8'h2e
		|=> ##1 div_cfg[1].value[18:16] == $past(req.wdata[2:0], 2)) else $error("input 2 high bits wrong");
	a_in3_mid_byte: assert property (req.wr && req.addr == 8'h32
		|=> ##1 div_cfg[2].value[15:8] == $past(req.wdata, 2)) else $error("input 3 mid byte wrong");
	a_in4_low_byte: assert property (req.wr && req.addr == 8'h36
		|=> ##1 div_cfg[3].value[7:0] == $past(req.wdata, 2)) else $error("input 4 low byte wrong");
	a_band_write: assert property (req.wr && req.addr == 8'h37
		|=> ##1 band_cfg[0].code == $past(req.wdata[2:0], 2)
		&& band_cfg[1].code == $past(req.wdata[5:3], 2)) else $error("band codes wrong");
	// change pulse only with a value that really moved
	a_change_pulse: assert property (div_cfg[0].changed |-> div_cfg[0].value != $past(div_cfg[0].value))
		else $error("change pulse without new value");
	// zero value must mean divide by one, so ratio is value plus one
	a_ratio_plus_one: assert property (div_cfg[0].ratio == div_cfg[0].value + 20'h0_0001
		&& div_cfg[2].ratio == div_cfg[2].value + 20'h0_0001) else $error("ratio not value plus one");
	a_band_reserved: assert property (
		band_cfg[1].reserved == (band_cfg[1].code >= idc_pkg::BAND_RSV_FIRST))
		else $error("reserved flag wrong");
	a_reset_low: assert property ($rose(rst_n) |-> div_cfg[1].value == 19'h0_0009
		&& div_cfg[3].value == 19'h0_0009) else $error("low byte reset wrong");
endmodule : idc_top_properties

bind idc_top idc_top_properties u_props (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
	.rd_valid(rd_valid), .unmapped(unmapped), .div_cfg(div_cfg), .band_cfg(band_cfg));

// file: test/idc_top_tb_top.sv
`timescale 1ns/10ps
module idc_top_tb_top;
	logic                     clk;
	logic                     rst_n;
	idc_pkg::idc_req_t        req;
	logic [7:0]               rd_data;
	logic                     rd_valid;
	logic                     unmapped;
	idc_pkg::idc_div_t [3:0]  div_cfg;
	idc_pkg::idc_band_t [1:0] band_cfg;
	logic [7:0]               shadow [8'h2b:8'h37];
	logic [8:0]               exp_q [$];
	int                       fails;
	int                       n_compared;

	idc_top u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
		.unmapped(unmapped), .div_cfg(div_cfg), .band_cfg(band_cfg));

	// ======================
	// clock and helpers
	// ======================
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	// one request per cycle; a read notes the old value, so a same-cycle write cannot leak in
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		logic hit;
		hit = (a >= 8'h2b) && (a <= 8'h37);
		@(posedge clk);
		#1;
		req = '{wr: w, rd: r, addr: a, wdata: d};
		if (r)
			exp_q.push_back({!hit, hit ? shadow[a] : 8'h00});
		if (w && hit)
			shadow[a] = d & (a == 8'h37 ? 8'h3f : (a % 3 == 1 ? 8'h07 : 8'hff));
	endtask : op

	task automatic reset_shadow;
		foreach (shadow[i])
			shadow[i] = 8'h00;
		shadow[8'h30] = 8'h09;
		shadow[8'h36] = 8'h09;
	endtask : reset_shadow

	task automatic read_all;
		for (int a = 8'h2b; a <= 8'h37; a++)
			op(1'b0, 1'b1, a[7:0], 8'h00);
		op(1'b0, 1'b0, 8'h00, 8'h00);
	endtask : read_all

	// idle long enough for the two-cycle datapath latency, then compare
	task automatic check_cfg;
		logic [18:0] v;
		logic [2:0]  c;
		repeat (3) op(1'b0, 1'b0, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = {shadow[8'h2b + 3 * i][2:0], shadow[8'h2c + 3 * i], shadow[8'h2d + 3 * i]};
			check(div_cfg[i].value, v);
			check(div_cfg[i].ratio, v + 20'h0_0001);
		end
		for (int j = 0; j < 2; j++) begin
			c = shadow[8'h37][3 * j +: 3];
			check(band_cfg[j].code, c);
			check(band_cfg[j].lo_mhz, idc_pkg::BAND_LO_MHZ[c]);
			check(band_cfg[j].hi_mhz, idc_pkg::BAND_HI_MHZ[c]);
		end
	endtask : check_cfg

	// bounded wait for every noted read to come back
	task automatic drain(input string name);
		int k;
		k = 0;
		while (exp_q.size() > 0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		if (exp_q.size() > 0) begin
			fails++;
			summarize();
		end
		$display("test %s done", name);
	endtask : drain

	// oldest note against each read answer, sampled mid-cycle when settled
	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check(20'h0_0000, 20'h0_0001);
			else
				check({unmapped, rd_data}, exp_q.pop_front());
		end
	end

	initial begin
		#100us;
		fails++;
		summarize();
	end

	initial begin
		logic [7:0] d;
		fails = 0;
		n_compared = 0;
		req = '0;
		rst_n = 1'b0;
		void'($urandom(6449));
		reset_shadow();
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		read_all();
		check_cfg();
		drain("reset");
		// round 0 writes zeros to the divider bytes, not the band byte: divide by one
		for (int r = 0; r < 4; r++) begin
			for (int a = 8'h2b; a <= 8'h37; a++) begin
				d = (r == 0) ? 8'h00 : 8'($urandom);
				if (a == 8'h37)
					d = {2'b00, 3'($urandom % 6), 3'($urandom % 6)};
				else if (a % 3 == 1)
					d = d & 8'h07;
				op(1'b1, 1'b0, a[7:0], d);
			end
			read_all();
			check_cfg();
		end
		drain("divider values");
		// every legal band code on both fields, with a same-cycle read
		for (int c = 0; c < 6; c++) begin
			op(1'b1, 1'b1, 8'h37, {2'b00, 3'(5 - c), 3'(c)});
			check_cfg();
		end
		drain("band codes");
		op(1'b1, 1'b1, 8'h2a, 8'h5a);
		op(1'b0, 1'b1, 8'h38, 8'h00);
		op(1'b1, 1'b0, 8'hff, 8'h11);
		read_all();
		drain("unmapped");
		op(1'b1, 1'b0, 8'h30, 8'h55);
		op(1'b0, 1'b0, 8'h00, 8'h00);
		rst_n = 1'b0;
		reset_shadow();
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		read_all();
		check_cfg();
		drain("second reset");
		summarize();
	end
endmodule : idc_top_tb_top
